/* File: qei_consts.svh */
// Register offsets, layout widths and reset values of the quadrature encoder interface.
`ifndef QEI_CONSTS_SVH
`define QEI_CONSTS_SVH

`define QEI_OFF_CTL 12'h000
`define QEI_OFF_STAT 12'h004
`define QEI_OFF_POS 12'h008
`define QEI_OFF_LIMIT 12'h00C
`define QEI_OFF_LOAD 12'h010
`define QEI_OFF_TIMER 12'h014
`define QEI_OFF_ACCUM 12'h018
`define QEI_OFF_RESULT 12'h01C
`define QEI_OFF_MASK 12'h020
`define QEI_OFF_RAW 12'h024
`define QEI_OFF_CLR 12'h028

`define QEI_CTL_WIDTH 13
`define QEI_EVT_WIDTH 4
`define QEI_CTL_RESET 13'h0000
`define QEI_EVT_RESET 4'h0
`define QEI_WORD_RESET 32'h0000_0000
`define QEI_WORD_ONE 32'h0000_0001
`define QEI_PREDIV_ONE 7'h01

`endif

/* File: qei_pkg.sv */
// Types shared by the quadrature encoder interface modules.
`default_nettype none
package qei_pkg;

   // Control word, bit 0 is enable, bit 12 is the debug halt freeze.
   typedef struct packed {
      logic debug_halt_freeze;
      logic invert_index;
      logic invert_second_phase;
      logic invert_first_phase;
      logic [2:0] velocity_prescale;
      logic velocity_capture_enable;
      logic position_wrap_select;
      logic edge_count_select;
      logic signal_format_select;
      logic swap;
      logic enable;
   } qei_ctl_t;

   // Event bits, bit 0 is the index event, bit 3 the phase error.
   typedef struct packed {
      logic phase_error;
      logic dir_change;
      logic timer_expiry;
      logic index_seen;
   } qei_evt_t;

   typedef struct packed {
      logic index;
      logic second;
      logic first;
   } qei_pins_t;

   typedef struct packed {
      qei_pins_t stage1;
      qei_pins_t stage2;
   } qei_sync_t;

   typedef struct packed {
      qei_ctl_t ctl;
      logic [31:0] position;
      logic [31:0] position_limit;
      logic [31:0] velocity_period_load;
      logic [31:0] timer;
      logic [31:0] velocity_accumulator;
      logic [31:0] velocity_result;
      logic [6:0] prediv;
      qei_evt_t mask;
      qei_evt_t raw;
      logic prev_a;
      logic prev_b;
      logic prev_index;
      logic reverse;
      logic [31:0] prdata;
   } qei_state_t;

endpackage
`default_nettype wire

/* File: qei_sync.sv */
// Two-stage synchroniser for the encoder pins.
`timescale 1ns/1ps
`default_nettype none
module qei_sync
   import qei_pkg::*;
(
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable, freezes the stages when low.
   input wire qei_pins_t pins_async, // Raw encoder pins.
   output qei_pins_t pins_sync // Pins after two flip-flops.
);
   qei_sync_t st;
   qei_sync_t next_st;

   // RULE20 two-stage synchroniser
   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.stage1 = pins_async;
         next_st.stage2 = st.stage1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pins_sync = st.stage2;
endmodule
`default_nettype wire

/* File: qei_top.sv */
// Quadrature encoder interface with APB register slave.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "qei_consts.svh"

// Functional notes
// RULE1 - Format select chooses quadrature phases or clock plus direction interpretation.
// RULE2 - Clock/direction: first input steps, second input gives rotation direction.
// RULE3 - Swap exchanges first and second phase before decoding.
// RULE4 - Velocity capture has its own enable and needs position enabled.
// RULE5 - Quadrature: count first-phase edges only, or edges of both phases.
// RULE6 - First phase leading second phase increments the position.
// RULE7 - Second phase leading first phase decrements the position.
// RULE8 - An edge pair on one phase alone means the direction reversed.
// RULE9 - Wrap select 0: index pulse clears the position to zero.
// RULE10 - Stepping back from zero loads the position limit.
// RULE11 - Wrap select 1: position stays within zero to limit, index ignored.
// RULE12 - Velocity accumulator counts the same qualified edges each timer period.
// RULE13 - At period end accumulator moves to result, then clears to zero.
// RULE14 - Timer counts down, reloads at zero, keeps running, raises expiry event.
// RULE15 - Events: phase error, direction change, index, timer expiry.
// RULE16 - Events have mask, raw status, masked status and per-bit clear.
// RULE17 - Prescale code n divides velocity edges by two to the n.
// RULE18 - Separate inversions for first phase, second phase and index.
// RULE19 - Debug halt freeze stops counting while the processor is halted.
// RULE20 - Phase and index pins are synchronised before edge detection.
// RULE21 - Both phases changing together is a phase error, position unchanged.
module qei_top
   import qei_pkg::*;
(
   input wire logic pclk, // System clock, 20 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable, freezes all state when low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped addresses.
   input wire logic first_phase_input, // Encoder first phase pin.
   input wire logic second_phase_input, // Encoder second phase pin.
   input wire logic index_input, // Encoder index pin.
   input wire logic cpu_halt, // Processor halt indication, same clock.
   output logic irq // Any unmasked pending event.
);
   qei_state_t st;
   qei_state_t next_st;
   qei_pins_t pins_async;
   qei_pins_t pins;

   logic bus_access;
   logic bus_write;
   logic pos_write;
   logic raw_a;
   logic raw_b;
   logic phase_a;
   logic phase_b;
   logic index_lvl;
   logic run;
   logic vel_run;
   logic edge_a;
   logic edge_b;
   logic index_rise;
   logic quad_err;
   logic step_quad;
   logic fwd_quad;
   logic step_clk;
   logic step;
   logic fwd;
   logic moved;
   logic dir_flip;
   logic index_clear;
   logic [6:0] pre_mask;
   logic vel_inc;
   logic period_end;
   qei_evt_t new_evt;

   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a[1:0] == 2'h0) && (a <= `QEI_OFF_CLR);
   endfunction

   function automatic logic [31:0] read_word(input logic [11:0] a, input qei_state_t s);
      read_word = `QEI_WORD_RESET;
      case (a)
         `QEI_OFF_CTL: read_word = 32'(s.ctl);
         `QEI_OFF_STAT: read_word = {30'h0000_0000, s.reverse, s.raw.phase_error};
         `QEI_OFF_POS: read_word = s.position;
         `QEI_OFF_LIMIT: read_word = s.position_limit;
         `QEI_OFF_LOAD: read_word = s.velocity_period_load;
         `QEI_OFF_TIMER: read_word = s.timer;
         `QEI_OFF_ACCUM: read_word = s.velocity_accumulator;
         `QEI_OFF_RESULT: read_word = s.velocity_result;
         `QEI_OFF_MASK: read_word = 32'(s.mask);
         `QEI_OFF_RAW: read_word = 32'(s.raw);
         `QEI_OFF_CLR: read_word = 32'(s.raw & s.mask);
         default: read_word = `QEI_WORD_RESET;
      endcase
   endfunction

   // A position outside the limit, left by software, is pulled back on the next step.
   function automatic logic [31:0] next_position(input logic [31:0] pos, input logic [31:0] lim,
                                                 input logic up);
      if (up) begin
         next_position = (pos >= lim) ? `QEI_WORD_RESET : pos + `QEI_WORD_ONE;
      end else begin
         next_position = (pos == `QEI_WORD_RESET || pos > lim) ? lim : pos - `QEI_WORD_ONE;
      end
   endfunction

   assign pins_async = '{index: index_input, second: second_phase_input, first: first_phase_input};

   // RULE20 two-flop synchroniser
   qei_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .pins_async(pins_async),
      .pins_sync(pins)
   );

   // Stalling on ce keeps the bus from losing a write while state is frozen.
   assign pready = ce;
   assign pslverr = psel && penable && !addr_mapped(paddr);
   assign bus_access = psel && penable && ce;
   assign bus_write = bus_access && pwrite;
   assign pos_write = bus_write && (paddr == `QEI_OFF_POS);
   assign prdata = st.prdata;
   assign irq = |(st.raw & st.mask);

   // RULE18 per-input inversion
   assign raw_a = pins.first ^ st.ctl.invert_first_phase;
   assign raw_b = pins.second ^ st.ctl.invert_second_phase;
   assign index_lvl = pins.index ^ st.ctl.invert_index;
   // RULE3 phase swap
   assign phase_a = st.ctl.swap ? raw_b : raw_a;
   assign phase_b = st.ctl.swap ? raw_a : raw_b;

   // RULE19 halt freeze
   assign run = ce && st.ctl.enable && !(st.ctl.debug_halt_freeze && cpu_halt);
   // RULE4 velocity needs position enable
   assign vel_run = run && st.ctl.velocity_capture_enable;

   assign edge_a = phase_a ^ st.prev_a;
   assign edge_b = phase_b ^ st.prev_b;
   assign index_rise = index_lvl && !st.prev_index;

   // RULE21 simultaneous phase change
   assign quad_err = !st.ctl.signal_format_select && edge_a && edge_b;
   // RULE5 edge count select
   assign step_quad = !quad_err && (edge_a || (edge_b && st.ctl.edge_count_select));
   // RULE6 RULE7 lead decides direction
   assign fwd_quad = edge_a ? (phase_a != phase_b) : (phase_a == phase_b);
   // RULE2 step clock and direction level
   assign step_clk = edge_a && phase_a;
   // RULE1 format select
   assign step = st.ctl.signal_format_select ? step_clk : step_quad;
   assign fwd = st.ctl.signal_format_select ? phase_b : fwd_quad;
   assign moved = st.ctl.signal_format_select ? step_clk : (!quad_err && (edge_a || edge_b));
   // RULE8 reversal detection
   assign dir_flip = moved && (fwd == st.reverse);

   // RULE11 index ignored in limit mode
   assign index_clear = !st.ctl.position_wrap_select && index_rise;

   // RULE17 prescale divide
   assign pre_mask = 7'((8'h01 << st.ctl.velocity_prescale) - 8'h01);
   // RULE12 same qualified edges
   assign vel_inc = vel_run && step && (st.prediv == pre_mask);
   assign period_end = vel_run && (st.timer == `QEI_WORD_RESET);

   // RULE15 event sources
   assign new_evt = '{phase_error: run && quad_err, dir_change: run && dir_flip,
                      timer_expiry: period_end, index_seen: run && index_rise};

   always_comb begin
      next_st = st;
      if (ce && psel && !penable) begin
         next_st.prdata = read_word(paddr, st);
      end
      if (run) begin
         next_st.prev_a = phase_a;
         next_st.prev_b = phase_b;
         next_st.prev_index = index_lvl;
         if (moved) begin
            next_st.reverse = !fwd;
         end
         // RULE9 index clears position
         if (index_clear) begin
            next_st.position = `QEI_WORD_RESET;
         end else if (step) begin
            // RULE10 reverse from zero loads limit
            next_st.position = next_position(st.position, st.position_limit, fwd);
         end
      end
      if (vel_run) begin
         if (step) begin
            next_st.prediv = (st.prediv == pre_mask) ? 7'h00 : st.prediv + `QEI_PREDIV_ONE;
         end
         // RULE14 countdown and reload
         if (period_end) begin
            next_st.timer = st.velocity_period_load;
            // RULE13 result capture and clear
            next_st.velocity_result = st.velocity_accumulator + 32'(vel_inc);
            next_st.velocity_accumulator = `QEI_WORD_RESET;
         end else begin
            next_st.timer = st.timer - `QEI_WORD_ONE;
            next_st.velocity_accumulator = st.velocity_accumulator + 32'(vel_inc);
         end
      end else if (ce && !(st.ctl.enable && st.ctl.velocity_capture_enable)) begin
         // Only a disabled capture restarts from empty; a debug halt must freeze the period instead.
         next_st.timer = st.velocity_period_load;
         next_st.velocity_accumulator = `QEI_WORD_RESET;
         next_st.prediv = 7'h00;
      end
      // RULE16 raw status, set wins over clear
      next_st.raw = st.raw;
      if (bus_write && paddr == `QEI_OFF_CLR) begin
         next_st.raw = st.raw & ~qei_evt_t'(pwdata[`QEI_EVT_WIDTH-1:0]);
      end
      next_st.raw = next_st.raw | new_evt;
      if (bus_write) begin
         case (paddr)
            `QEI_OFF_CTL: next_st.ctl = qei_ctl_t'(pwdata[`QEI_CTL_WIDTH-1:0]);
            `QEI_OFF_POS: next_st.position = pwdata;
            `QEI_OFF_LIMIT: next_st.position_limit = pwdata;
            `QEI_OFF_LOAD: next_st.velocity_period_load = pwdata;
            `QEI_OFF_MASK: next_st.mask = qei_evt_t'(pwdata[`QEI_EVT_WIDTH-1:0]);
            default: next_st.mask = st.mask;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_idle_pos;
      run && !pos_write && !index_clear;
   endsequence

   sequence s_period_end;
      vel_run && st.timer == `QEI_WORD_RESET;
   endsequence

   index_clears_a: // RULE9
   assert property (run && index_clear && !pos_write |=> st.position == `QEI_WORD_RESET)
      else $error("Index pulse did not clear the position.");

   fwd_increment_a: // RULE6
   assert property (s_idle_pos ##0 (step && fwd && st.position < st.position_limit)
                    |=> st.position == $past(st.position) + `QEI_WORD_ONE)
      else $error("Forward step did not increment the position.");

   rev_decrement_a: // RULE7
   assert property (s_idle_pos ##0 (step && !fwd && st.position != `QEI_WORD_RESET &&
                    st.position <= st.position_limit)
                    |=> st.position == $past(st.position) - `QEI_WORD_ONE)
      else $error("Reverse step did not decrement the position.");

   rev_wrap_a: // RULE10
   assert property (s_idle_pos ##0 (step && !fwd && st.position == `QEI_WORD_RESET)
                    |=> st.position == $past(st.position_limit))
      else $error("Reverse step from zero did not load the limit.");

   error_hold_a: // RULE21
   assert property (run && quad_err && !pos_write
                    |=> st.position == $past(st.position) && st.raw.phase_error)
      else $error("Phase error moved the position or was not flagged.");

   timer_reload_a: // RULE14
   assert property (s_period_end |=> st.timer == $past(st.velocity_period_load) && st.raw.timer_expiry)
      else $error("Timer did not reload or flag expiry at zero.");

   velocity_copy_a: // RULE13
   assert property (s_period_end |=> st.velocity_result == $past(st.velocity_accumulator) + 32'($past(vel_inc))
                    && st.velocity_accumulator == `QEI_WORD_RESET)
      else $error("Period end did not move the accumulator to the result.");

   set_wins_a: // RULE16
   assert property (bus_write && paddr == `QEI_OFF_CLR && |new_evt |=> (st.raw & $past(new_evt)) == $past(new_evt))
      else $error("Clearing lost an event raised in the same cycle.");

   halt_freeze_a: // RULE19
   assert property (ce && st.ctl.debug_halt_freeze && cpu_halt && !bus_write
                    |=> st.position == $past(st.position) && st.timer == $past(st.timer))
      else $error("Counting continued during a debug halt.");

   prescale_gate_a: // RULE17
   assert property (vel_run && step && st.prediv != pre_mask && !period_end
                    |=> st.velocity_accumulator == $past(st.velocity_accumulator))
      else $error("Velocity edge passed the prescaler too early.");

   velocity_count_a: // RULE12
   assert property (vel_inc && !period_end
                    |=> st.velocity_accumulator == $past(st.velocity_accumulator) + `QEI_WORD_ONE)
      else $error("Qualified edge was not added to the accumulator.");

   timer_count_a: // RULE14
   assert property (vel_run && st.timer != `QEI_WORD_RESET
                    |=> st.timer == $past(st.timer) - `QEI_WORD_ONE)
      else $error("Timer did not count down.");

   velocity_gate_a: // RULE4
   assert property (ce && !st.ctl.enable |=> st.velocity_accumulator == `QEI_WORD_RESET)
      else $error("Velocity counted without position enabled.");

   dir_event_a: // RULE8
   assert property (run && moved && fwd == st.reverse
                    |=> st.raw.dir_change && st.reverse == !$past(fwd))
      else $error("Direction reversal was not flagged.");

   index_event_a: // RULE15
   assert property (run && index_rise |=> st.raw.index_seen)
      else $error("Index pulse did not raise its event.");

   event_clear_a: // RULE16
   assert property (bus_write && paddr == `QEI_OFF_CLR && pwdata[0] && !new_evt.index_seen
                    |=> !st.raw.index_seen)
      else $error("Writing one did not clear the index event.");

   first_only_a: // RULE5
   assert property (s_idle_pos ##0 (!st.ctl.signal_format_select && !st.ctl.edge_count_select
                    && edge_b && !edge_a)
                    |=> st.position == $past(st.position))
      else $error("Second phase edge moved the position.");

   clock_dir_a: // RULE2
   assert property (s_idle_pos ##0 (st.ctl.signal_format_select && edge_a && !phase_a)
                    |=> st.position == $past(st.position))
      else $error("Falling step clock moved the position.");

   limit_mode_a: // RULE11
   assert property (s_idle_pos ##0 (st.ctl.position_wrap_select && index_rise && !step)
                    |=> st.position == $past(st.position))
      else $error("Index changed the position in limit mode.");

endmodule
`default_nettype wire

/* File: qei_enc_model.sv */
// Behavioural incremental encoder driving the two phase pins and the index pin.
`timescale 1ns/1ps
`default_nettype none
module qei_enc_model (
   input wire logic clk, // Bench clock.
   input wire logic [3:0] hold, // Clocks each pin level is held.
   output logic first_phase_input, // First phase pin.
   output logic second_phase_input, // Second phase pin.
   output logic index_input // Index pin.
);
   initial begin
      first_phase_input = 1'b0;
      second_phase_input = 1'b0;
      index_input = 1'b0;
   end
   task automatic wait_hold();
      repeat (hold) @(posedge clk);
   endtask
   // quadrature gray order
   // Forward order is 00, 10, 11, 01, so only one phase moves per step.
   task automatic step(input bit fwd);
      @(posedge clk);
      if ((first_phase_input == second_phase_input) == fwd) first_phase_input <= ~first_phase_input;
      else second_phase_input <= ~second_phase_input;
      wait_hold();
   endtask
   // Both phases moving on one edge is a fault that a healthy encoder never shows.
   task automatic both();
      @(posedge clk);
      first_phase_input <= ~first_phase_input;
      second_phase_input <= ~second_phase_input;
      wait_hold();
   endtask
   task automatic cd_step(input bit fwd);
      @(posedge clk);
      first_phase_input <= 1'b0;
      second_phase_input <= fwd;
      wait_hold();
      first_phase_input <= 1'b1;
      wait_hold();
   endtask
   task automatic pulse();
      @(posedge clk);
      index_input <= 1'b1;
      wait_hold();
      index_input <= 1'b0;
      wait_hold();
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the quadrature encoder interface with a position model.
`timescale 1ns/1ps
`default_nettype none
`include "qei_consts.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cpu_halt = 1'b0;
   logic ce = 1'b1;
   logic irq;
   logic [3:0] hold = 4'h4;
   logic pa;
   logic pb;
   logic pi;
   logic [31:0] q;
   logic err;
   int failures = 0;
   int checks = 0;
   int mpos;
   int lim;
   always #25 pclk = ~pclk;
   qei_top qei_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_phase_input(pa), .second_phase_input(pb), .index_input(pi), .cpu_halt(cpu_halt), .irq(irq));
   qei_enc_model enc (.clk(pclk), .hold(hold), .first_phase_input(pa), .second_phase_input(pb), .index_input(pi));
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic done(input string nm);
      $display("test %s finished, checks %0d failures %0d", nm, checks, failures);
   endtask
   // An idle edge after each transfer keeps two requests from landing in one time step.
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] e, input string nm);
      apb(1'b0, ad, 32'h0000_0000);
      `CHK(nm, e, q)
   endtask
   task automatic mv(input bit fwd, input bit counted);
      enc.step(fwd);
      if (counted && fwd) mpos = (mpos >= lim) ? 0 : mpos + 1;
      else if (counted) mpos = (mpos == 0 || mpos > lim) ? lim : mpos - 1;
   endtask
   task automatic setpos(input int v);
      apb(1'b1, `QEI_OFF_POS, 32'(v));
      mpos = v;
   endtask
   initial begin
      int i;
      int n;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      void'($urandom(32'h0870));
      for (i = 0; i < 11; i++) rd(12'(i * 4), 32'h0000_0000, "reset value");
      apb(1'b0, 12'h02C, 32'h0000_0000);
      `CHK("unmapped error", 1'b1, err)
      done("reset");
      lim = 5 + $urandom % 12;
      apb(1'b1, `QEI_OFF_LIMIT, 32'(lim));
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0019);
      mpos = 0;
      for (i = 0; i < 40; i++) begin
         mv(1'($urandom % 2), 1'b1);
         rd(`QEI_OFF_POS, 32'(mpos), "walk position");
      end
      enc.pulse();
      rd(`QEI_OFF_POS, 32'(mpos), "index ignored");
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0009);
      mv(1'b1, 1'b1);
      enc.pulse();
      rd(`QEI_OFF_POS, 32'h0000_0000, "index clear");
      mv(1'b0, 1'b1);
      rd(`QEI_OFF_POS, 32'(lim), "reverse from zero");
      rd(`QEI_OFF_RAW, 32'h0000_0005, "raw events");
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, `QEI_OFF_MASK, 32'h0000_0001);
      `CHK("irq raised", 1'b1, irq)
      rd(`QEI_OFF_CLR, 32'h0000_0001, "masked status");
      apb(1'b1, `QEI_OFF_CLR, 32'h0000_000F);
      rd(`QEI_OFF_RAW, 32'h0000_0000, "raw cleared");
      `CHK("irq cleared", 1'b0, irq)
      done("position and events");
      apb(1'b1, `QEI_OFF_LIMIT, 32'h0000_0064);
      lim = 100;
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0001);
      setpos(0);
      for (i = 0; i < 4; i++) mv(1'b1, 1'b0);
      rd(`QEI_OFF_POS, 32'h0000_0002, "first phase only");
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_000B);
      setpos(10);
      for (i = 0; i < 3; i++) enc.step(1'b1);
      rd(`QEI_OFF_POS, 32'h0000_0007, "swapped phases");
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0009);
      setpos(5);
      apb(1'b1, `QEI_OFF_CLR, 32'h0000_000F);
      enc.both();
      rd(`QEI_OFF_POS, 32'h0000_0005, "error keeps position");
      rd(`QEI_OFF_RAW, 32'h0000_0008, "phase error event");
      hold <= 4'h9;
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0005);
      setpos(20);
      for (i = 0; i < 4; i++) enc.cd_step(i < 3);
      rd(`QEI_OFF_POS, 32'h0000_0016, "clock direction");
      hold <= 4'h4;
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_1009);
      setpos(3);
      cpu_halt <= 1'b1;
      for (i = 0; i < 4; i++) enc.step(i < 2);
      rd(`QEI_OFF_POS, 32'h0000_0003, "halted");
      cpu_halt <= 1'b0;
      enc.step(1'b1);
      rd(`QEI_OFF_POS, 32'h0000_0004, "resumed");
      ce <= 1'b0;
      enc.step(1'b1);
      `CHK("pready frozen", 1'b0, pready)
      enc.step(1'b0);
      ce <= 1'b1;
      rd(`QEI_OFF_POS, 32'h0000_0004, "clock enable freeze");
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0A09);
      setpos(10);
      enc.step(1'b1);
      enc.step(1'b1);
      rd(`QEI_OFF_POS, 32'h0000_0008, "inverted first phase");
      enc.pulse();
      rd(`QEI_OFF_POS, 32'h0000_0000, "inverted index");
      done("modes");
      for (n = 0; n < 4; n++) begin
         apb(1'b1, `QEI_OFF_CTL, 32'h0000_0009);
         apb(1'b1, `QEI_OFF_LOAD, 32'h0000_012C);
         apb(1'b1, `QEI_OFF_CTL, 32'(32'h0000_0029 | (n << 6)));
         for (i = 0; i < 8; i++) enc.step(1'b1);
         rd(`QEI_OFF_ACCUM, 32'(8 >> n), "accumulated edges");
         i = 0;
         do begin
            apb(1'b0, `QEI_OFF_RAW, 32'h0000_0000);
            i++;
         end while (q[1] !== 1'b1 && i < 200);
         `CHK("timer expiry", 1'b1, q[1])
         if (q[1] !== 1'b1) report_and_stop();
         rd(`QEI_OFF_RESULT, 32'(8 >> n), "velocity result");
         rd(`QEI_OFF_ACCUM, 32'h0000_0000, "accumulator cleared");
         apb(1'b0, `QEI_OFF_TIMER, 32'h0000_0000);
         `CHK("timer reloaded", 1'b1, q > 32'h0000_00FA && q <= 32'h0000_012C)
         apb(1'b1, `QEI_OFF_CLR, 32'h0000_000F);
      end
      apb(1'b1, `QEI_OFF_CTL, 32'h0000_0020);
      enc.step(1'b1);
      enc.step(1'b1);
      rd(`QEI_OFF_ACCUM, 32'h0000_0000, "velocity needs position");
      done("velocity");
      report_and_stop();
   end
endmodule
`default_nettype wire
